//--- fdxp_pkg.sv
// Package: register map, field layout, timing constants and types of the transfer block
package fdxp_pkg;
   // APB register byte offsets
   localparam logic [7:0] ADDR_CMD     = 8'h00;
   localparam logic [7:0] ADDR_DATA    = 8'h04;
   localparam logic [7:0] ADDR_CFG     = 8'h08;
   localparam logic [7:0] ADDR_PERP    = 8'h0C;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_RESULT  = 8'h14;
   localparam logic [7:0] ADDR_RATE    = 8'h18;
   localparam logic [7:0] ADDR_DIR     = 8'h1C;

   localparam int unsigned CLK_HZ       = 20_000_000;
   localparam int unsigned WAKE_SHORT_US = 10_000;
   localparam int unsigned WAKE_LONG_US  = 500_000;
   localparam int unsigned STEP_UNIT_US  = 500;
   localparam int unsigned WAKE_SHORT_CYC = CLK_HZ / 1_000_000 * WAKE_SHORT_US;
   localparam int unsigned WAKE_LONG_CYC  = CLK_HZ / 1_000_000 * WAKE_LONG_US;
   localparam int unsigned STEP_UNIT_CYC  = CLK_HZ / 1_000_000 * STEP_UNIT_US;

   localparam int unsigned CMD_BYTES    = 9;
   localparam int unsigned BASE_SECTOR  = 128;
   localparam logic [2:0]  MAX_SIZE_CODE = 3'h7;
   localparam logic [7:0]  FULL_LENGTH  = 8'hFF;
   localparam logic [7:0]  ERR_SEEK     = 8'h60;
   localparam logic [7:0]  ERR_BADCMD   = 8'h80;

   // Rate codes and tables
   localparam logic [1:0] RATE_1M   = 2'h3;
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [1:0] RATE_300K = 2'h2;
   localparam logic [1:0] RATE_250K = 2'h1;
   localparam logic [1:0] TBL_CONV  = 2'h0;
   localparam logic [1:0] TBL_TAPE  = 2'h1;
   localparam logic [1:0] TBL_RSVD  = 2'h2;

   typedef enum logic [2:0] {
      SPD_250K, SPD_300K, SPD_500K, SPD_1M, SPD_2M, SPD_NONE
   } fdxp_speed_t;

   typedef struct packed {
      logic       lock;
      logic       alt_format;
      logic       compat_status_mirror;
      logic       idle_flag_mask;
      logic       osc_shutoff;
      logic       auto_sleep_enable;
      logic       min_awake_time_select;
      logic       auto_seek_enable;
      logic       fifo_off;
      logic       polling_disable;
      logic [3:0] fifo_threshold;
      logic [7:0] precomp_first_track;
      logic [3:0] step_interval;
      logic       programmed_io_mode;
      logic       suppress_result_phase;
   } fdxp_cfg_t;

   localparam logic [3:0] FIFO_THR_DEFAULT = 4'h0;
   localparam logic [7:0] PRECOMP_FIRST_TRACK_DEFAULT   = 8'h00;

   typedef struct packed {
      logic       both_heads_track_mode;
      logic       double_density_select;
      logic       deleted_sector_skip;
      logic       want_deleted;
      logic [1:0] drive;
      logic       head;
      logic [7:0] cyl;
      logic [7:0] sector;
      logic [2:0] size_code;
      logic [7:0] last_sector;
      logic [7:0] short_transfer_length;
   } fdxp_cmd_t;

   typedef struct packed {
      logic       valid;
      logic       deleted;
      logic       crc_ok;
      logic [7:0] data;
   } fdxp_disk_t;
endpackage

//--- fdxp_read.sv
// Read-data transfer engine with configuration registers on APB
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Rate code maps through chosen table; tape 10 means 2 Mbps, reads back 11.
// - Alternate format bit is only stored and read back, no logic uses it; resets to zero.
// - Lock bit keeps fifo and precomp settings through a software reset.
// - Auto sleep awake time 10 ms or 0.5 s, halved at 2 Mbps.
// - Both-heads mode continues from last head 0 sector to head 1.
// - Sector length is 128 shifted by size code 0 to 7.
// - Programmed io raises a request per byte, else DMA handshake.
// - Suppress result flag skips the result phase.
// - Perpendicular flags update only with the write allow bit.
// - Oscillator shutoff bit disables internal oscillator.
// - Compat mirror shows sleep and idle in bits 5,6 unless masked.
// - Per drive precomp bypass removes precompensation delay.
// - Polling disable bit stops drive polling.
// - Skip flag passes over sectors of the unwanted mark type.
// - Step interval in 0.5 ms units, scaled by data rate.
// - Precompensation applies from programmed first track upward.
// - Implied seek holds drive busy; failure reports error and cylinder.
// - Nine command bytes; load head, settle, match ID, move data.
// - After each sector before the last, increment sector number and continue.
// - Terminal count stops delivery; finish sector, check CRC, end.
// - Size zero transfers short length bytes but reads full sector.
module fdxp_read #(
   parameter int unsigned WAKE_SHORT = fdxp_pkg::WAKE_SHORT_CYC,
   parameter int unsigned WAKE_LONG  = fdxp_pkg::WAKE_LONG_CYC,
   parameter int unsigned STEP_UNIT  = fdxp_pkg::STEP_UNIT_CYC,
   parameter int unsigned SETTLE     = 16
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire fdxp_pkg::fdxp_disk_t disk_in,
   input  wire logic              transfer_end_signal,
   input  wire logic              dma_acknowledge_n,
   input  wire logic              seek_done,
   input  wire logic              seek_fail,
   output logic                   dma_request,
   output logic                   byte_irq,
   output logic                   seek_start,
   output logic [7:0]             seek_cyl,
   output logic                   step_tick,
   output logic                   osc_enable,
   output logic                   polling_enable,
   output logic                   precomp_active,
   output logic                   awake,
   output logic                   head_loaded
);
   import fdxp_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SEEK, ST_SETTLE, ST_SCAN, ST_DATA, ST_RESULT
   } fdxp_state_t;

   fdxp_state_t state;
   fdxp_cfg_t   cfg;
   fdxp_cmd_t   cmd;
   logic [1:0]  rate_code;
   logic [1:0]  rate_table;
   logic [3:0]  per_drive_perp_flags;
   logic [3:0]  precomp_bypass;
   logic [3:0]  cmd_count;
   logic [7:0]  data_hold;
   logic        data_full;
   logic [14:0] byte_count;
   logic        delivering;
   logic        stopping;
   logic [7:0]  result_status_0;
   logic [7:0]  result_cyl;
   logic [7:0]  settle_cnt;
   logic [31:0] wake_cnt;
   logic [31:0] step_cnt;
   logic [3:0]  busy_drive;
   logic        cmd_done;
   logic        soft_reset;
   logic        te_s1;
   logic        te_s2;
   logic        ack_s1;
   logic        ack_s2;

   wire wr = psel && penable && pwrite;
   wire rd = psel && penable && !pwrite;
   wire data_rd = rd && paddr == ADDR_DATA;
   wire data_taken = data_full && (cfg.programmed_io_mode ? data_rd : !ack_s2);

   // Sector length and transferred count
   wire [14:0] sector_len = 15'(BASE_SECTOR) << cmd.size_code;
   wire [14:0] xfer_len   = (cmd.size_code == 3'h0) ?
                            {7'h00, cmd.short_transfer_length} : sector_len;
   wire last_hit   = cmd.sector == cmd.last_sector;
   wire sector_end = disk_in.valid && byte_count == sector_len - 15'h1;
   wire match_skip = cmd.deleted_sector_skip && (disk_in.deleted != cmd.want_deleted);

   // Rate decode
   fdxp_speed_t speed;
   logic [1:0]  rate_readback;
   always_comb begin
      speed = SPD_NONE;
      rate_readback = rate_code;
      case (rate_code)
         RATE_1M:   speed = SPD_1M;
         RATE_500K: speed = SPD_500K;
         RATE_300K: speed = (rate_table == TBL_TAPE) ? SPD_2M : SPD_300K;
         RATE_250K: speed = SPD_250K;
         default:   speed = SPD_NONE;
      endcase
      if (rate_table == TBL_TAPE && rate_code == RATE_300K) rate_readback = RATE_1M;
      if (rate_table == TBL_RSVD) speed = SPD_NONE;
   end

   // Terminal count and DMA acknowledge inputs through two flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         te_s1  <= 1'b0;
         te_s2  <= 1'b0;
         ack_s1 <= 1'b1;
         ack_s2 <= 1'b1;
      end else begin
         te_s1  <= transfer_end_signal;
         te_s2  <= te_s1;
         ack_s1 <= dma_acknowledge_n;
         ack_s2 <= ack_s1;
      end
   end

   assign soft_reset = wr && paddr == ADDR_RATE && pwdata[7];

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg        <= '0;
         rate_code  <= RATE_500K;
         rate_table <= TBL_CONV;
         per_drive_perp_flags <= 4'h0;
         precomp_bypass <= 4'h0;
      end else if (soft_reset) begin
         rate_code <= RATE_500K;
         if (!cfg.lock) begin
            cfg.fifo_off            <= 1'b0;
            cfg.fifo_threshold      <= FIFO_THR_DEFAULT;
            cfg.precomp_first_track <= PRECOMP_FIRST_TRACK_DEFAULT;
         end
      end else if (wr) begin
         case (paddr)
            ADDR_CFG: begin
               cfg.lock                  <= pwdata[0];
               cfg.alt_format            <= pwdata[1];
               cfg.compat_status_mirror  <= pwdata[2];
               cfg.idle_flag_mask        <= pwdata[4];
               cfg.osc_shutoff           <= pwdata[5];
               cfg.auto_sleep_enable     <= pwdata[6];
               cfg.min_awake_time_select <= pwdata[7];
               cfg.auto_seek_enable      <= pwdata[8];
               cfg.fifo_off              <= pwdata[9];
               cfg.polling_disable       <= pwdata[10];
               cfg.programmed_io_mode    <= pwdata[11];
               cfg.suppress_result_phase <= pwdata[12];
               cfg.fifo_threshold        <= pwdata[19:16];
               cfg.step_interval         <= pwdata[23:20];
               cfg.precomp_first_track   <= pwdata[31:24];
            end
            ADDR_PERP: begin
               if (pwdata[7]) per_drive_perp_flags <= pwdata[5:2];
               precomp_bypass <= pwdata[11:8];
            end
            ADDR_RATE: begin
               rate_code  <= pwdata[1:0];
               rate_table <= pwdata[3:2];
            end
            default: ;
         endcase
      end
   end

   // Command byte collection: nine bytes starting a read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd       <= '0;
         cmd_count <= 4'h0;
         cmd_done  <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         if (state == ST_DATA && sector_end && !stopping && !last_hit)
            cmd.sector <= cmd.sector + 8'h01;
         if (state == ST_DATA && sector_end && !stopping && last_hit &&
             cmd.both_heads_track_mode && !cmd.head) begin
            cmd.head   <= 1'b1;
            cmd.sector <= 8'h01;
         end
         if (wr && paddr == ADDR_CMD && state == ST_IDLE) begin
            case (cmd_count)
               4'h0: begin
                  cmd.both_heads_track_mode <= pwdata[7];
                  cmd.double_density_select <= pwdata[6];
                  cmd.deleted_sector_skip   <= pwdata[5];
                  cmd.want_deleted          <= pwdata[3];
               end
               4'h1: begin
                  cmd.head  <= pwdata[2];
                  cmd.drive <= pwdata[1:0];
               end
               4'h2: cmd.cyl <= pwdata[7:0];
               4'h4: cmd.sector <= pwdata[7:0];
               4'h5: cmd.size_code <= (pwdata[7:0] > 8'(MAX_SIZE_CODE)) ?
                                      MAX_SIZE_CODE : pwdata[2:0];
               4'h6: cmd.last_sector <= pwdata[7:0];
               4'h8: cmd.short_transfer_length <= pwdata[7:0];
               default: ;
            endcase
            if (cmd_count == 4'(CMD_BYTES - 1)) begin
               cmd_count <= 4'h0;
               cmd_done  <= 1'b1;
            end else begin
               cmd_count <= cmd_count + 4'h1;
            end
         end
      end
   end

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= ST_IDLE;
         seek_start  <= 1'b0;
         seek_cyl    <= 8'h00;
         settle_cnt  <= 8'h00;
         byte_count  <= 15'h0000;
         delivering  <= 1'b0;
         stopping    <= 1'b0;
         head_loaded <= 1'b0;
         busy_drive  <= 4'h0;
         result_status_0 <= 8'h00;
         result_cyl  <= 8'h00;
      end else begin
         seek_start <= 1'b0;
         case (state)
            ST_IDLE: if (cmd_done) begin
               result_status_0 <= 8'h00;
               stopping <= 1'b0;
               if (cfg.auto_seek_enable) begin
                  state      <= ST_SEEK;
                  seek_start <= 1'b1;
                  seek_cyl   <= cmd.cyl;
                  busy_drive <= 4'h1 << cmd.drive;
               end else begin
                  state      <= ST_SETTLE;
               end
               settle_cnt <= head_loaded ? 8'(SETTLE) : 8'h00;
            end
            ST_SEEK: if (seek_fail) begin
               result_status_0 <= ERR_SEEK;
               result_cyl <= cmd.cyl;
               busy_drive <= 4'h0;
               state <= ST_RESULT;
            end else if (seek_done) begin
               busy_drive <= 4'h0;
               state <= ST_SETTLE;
            end
            ST_SETTLE: begin
               head_loaded <= 1'b1;
               if (settle_cnt == 8'(SETTLE)) state <= ST_SCAN;
               else settle_cnt <= settle_cnt + 8'h01;
            end
            ST_SCAN: if (disk_in.valid && disk_in.data == cmd.sector) begin
               state      <= ST_DATA;
               byte_count <= 15'h0000;
               delivering <= !match_skip;
            end
            ST_DATA: if (disk_in.valid) begin
               byte_count <= byte_count + 15'h1;
               if (byte_count == xfer_len - 15'h1) delivering <= 1'b0;
               if (te_s2 || (data_full && !data_taken)) begin
                  delivering <= 1'b0;
                  stopping   <= 1'b1;
               end
               if (sector_end) begin
                  if (!disk_in.crc_ok) result_status_0 <= 8'h40;
                  if (stopping || !disk_in.crc_ok ||
                      (last_hit && !(cmd.both_heads_track_mode && !cmd.head)))
                     state <= ST_RESULT;
                  else
                     state <= ST_SCAN;
                  result_cyl <= cmd.cyl;
               end
            end
            ST_RESULT: if (cfg.suppress_result_phase ||
                           (rd && paddr == ADDR_RESULT)) state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Byte hand-off to host or DMA
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_hold   <= 8'h00;
         data_full   <= 1'b0;
         dma_request <= 1'b0;
         byte_irq    <= 1'b0;
      end else begin
         if (data_taken) data_full <= 1'b0;
         if (state == ST_DATA && disk_in.valid && delivering && !stopping && !te_s2 &&
             (!data_full || data_taken)) begin
            data_hold <= disk_in.data;
            data_full <= 1'b1;
         end
         dma_request <= !cfg.programmed_io_mode && data_full && !data_taken;
         byte_irq    <= cfg.programmed_io_mode && data_full && !data_taken;
      end
   end

   // Awake window and step timer
   wire [31:0] wake_len_full = cfg.min_awake_time_select ? WAKE_LONG : WAKE_SHORT;
   wire [31:0] wake_len = (speed == SPD_2M) ? (wake_len_full >> 1) : wake_len_full;
   wire [31:0] step_len = STEP_UNIT * (32'(cfg.step_interval) + 32'h1);
   logic [31:0] step_scaled;
   always_comb begin
      case (speed)
         SPD_500K: step_scaled = step_len << 1;
         SPD_300K: step_scaled = (step_len * 32'hA) / 32'h3;
         SPD_250K: step_scaled = step_len << 2;
         SPD_2M:   step_scaled = step_len >> 1;
         default:  step_scaled = step_len;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt <= 32'h0;
         awake    <= 1'b1;
         step_cnt <= 32'h0;
         step_tick <= 1'b0;
      end else begin
         if (state != ST_IDLE || !cfg.auto_sleep_enable) begin
            wake_cnt <= 32'h0;
            awake    <= 1'b1;
         end else if (wake_cnt >= wake_len) begin
            awake <= 1'b0;
         end else begin
            wake_cnt <= wake_cnt + 32'h1;
         end
         step_tick <= 1'b0;
         if (state != ST_SEEK || step_cnt >= step_scaled - 32'h1) begin
            step_cnt  <= 32'h0;
            step_tick <= state == ST_SEEK;
         end else begin
            step_cnt <= step_cnt + 32'h1;
         end
      end
   end

   // Drive-facing levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_enable     <= 1'b1;
         polling_enable <= 1'b1;
         precomp_active <= 1'b0;
      end else begin
         osc_enable     <= !cfg.osc_shutoff;
         polling_enable <= !cfg.polling_disable;
         precomp_active <= !precomp_bypass[cmd.drive] &&
                           cmd.cyl >= cfg.precomp_first_track;
      end
   end

   // APB read side, single-cycle answer
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case (paddr)
         ADDR_DATA:   rd_mux = {24'h0, data_hold};
         ADDR_CFG:    rd_mux = {cfg.precomp_first_track, cfg.step_interval,
                                cfg.fifo_threshold, 3'h0, cfg.suppress_result_phase,
                                cfg.programmed_io_mode, cfg.polling_disable,
                                cfg.fifo_off, cfg.auto_seek_enable,
                                cfg.min_awake_time_select, cfg.auto_sleep_enable,
                                cfg.osc_shutoff, cfg.idle_flag_mask, 1'b0,
                                cfg.compat_status_mirror, cfg.alt_format, cfg.lock};
         ADDR_PERP:   rd_mux = {20'h0, precomp_bypass, 2'h0, per_drive_perp_flags, 2'h0};
         ADDR_STATUS: rd_mux = {20'h0, busy_drive, 1'b0, 3'(state), data_full,
                                head_loaded, awake, stopping};
         ADDR_RESULT: rd_mux = {8'h0, cmd.sector, result_cyl, result_status_0};
         ADDR_RATE:   rd_mux = {28'h0, rate_table, rate_readback};
         ADDR_DIR:    if (cfg.compat_status_mirror && !cfg.idle_flag_mask)
                         rd_mux = {25'h0, state == ST_IDLE, !awake, 5'h00};
         default:     rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         prdata  <= rd_mux;
         pslverr <= psel && !penable && (paddr[1:0] != 2'h0 || paddr > ADDR_DIR);
      end
   end
endmodule
`default_nettype wire

//--- fdxp_read_asserts.sv
// Checker: bus answer, mode and pin properties of the transfer block
`timescale 1ns/1ps
`default_nettype none
module fdxp_read_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dma_request,
   input wire logic        byte_irq,
   input wire logic        seek_start,
   input wire logic        osc_enable,
   input wire logic        polling_enable
);
   import fdxp_pkg::*;
   logic [31:0] cfg_q;
   // Shadow of the last configuration word, taken at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cfg_q <= 32'h0;
      else if (psel && penable && pwrite && paddr == ADDR_CFG)
         cfg_q <= pwdata;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   slverr_map_a: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
      else $error("error response does not match address");
   osc_off_a: assert property (##2 osc_enable == !$past(cfg_q[5]))
      else $error("oscillator enable does not follow shutoff bit");
   poll_off_a: assert property (##2 polling_enable == !$past(cfg_q[10]))
      else $error("polling enable does not follow disable bit");
   dma_mode_a: assert property (dma_request |-> !$past(cfg_q[11]))
      else $error("dma request in programmed io mode");
   pio_mode_a: assert property (byte_irq |-> $past(cfg_q[11]))
      else $error("byte interrupt in dma mode");
   seek_pulse_a: assert property (seek_start |=> !seek_start)
      else $error("seek start longer than one cycle");
   cover property (dma_request);
   cover property (byte_irq);
   cover property (seek_start);
   cover property (pready && pslverr);
endmodule
bind fdxp_read fdxp_read_asserts i_fdxp_read_asserts (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .dma_request, .byte_irq, .seek_start,
   .osc_enable, .polling_enable);
`default_nettype wire

//--- fdxp_dma_model.sv
// DMA controller model answering the byte request handshake
`timescale 1ns/1ps
`default_nettype none
module fdxp_dma_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        dma_request,
   input  wire logic [3:0]  lag,
   input  wire logic [15:0] tc_at,
   output logic             dma_acknowledge_n,
   output logic             transfer_end_signal,
   output logic [15:0]      taken
);
   logic [3:0] wait_cnt;
   // Ack held until request drops; the block sees it through a synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_acknowledge_n <= 1'b1;
         wait_cnt <= 4'h0;
         taken <= 16'h0;
      end else if (!dma_acknowledge_n) begin
         if (!dma_request)
            dma_acknowledge_n <= 1'b1;
      end else if (dma_request) begin
         if (wait_cnt == lag) begin
            dma_acknowledge_n <= 1'b0;
            taken <= taken + 16'h1;
            wait_cnt <= 4'h0;
         end else
            wait_cnt <= wait_cnt + 4'h1;
      end
   end
   // Terminal count rises with the last wanted byte; zero disables it
   assign transfer_end_signal = tc_at != 16'h0 && taken >= tc_at;
endmodule
`default_nettype wire

//--- fdxp_read_tb.sv
// Testbench: registers, rate mapping, modes and read transfers
`timescale 1ns/1ps
`default_nettype none
module fdxp_read_tb;
   import fdxp_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, dma_request, byte_irq, seek_start;
   logic        dma_acknowledge_n, transfer_end_signal, osc_enable, polling_enable;
   logic [7:0]  seek_cyl, want_cyl;
   logic        seek_done = 1'b0;
   logic        seek_fail = 1'b0;
   logic        fail_seek = 1'b0;
   fdxp_disk_t  disk_in = '0;
   logic [3:0]  lag = 4'h2;
   logic [15:0] tc_at = 16'h0;
   logic [15:0] taken, base;
   int          seclen = 256;
   int          mismatches = 0;
   int          checks_done = 0;
   fdxp_read #(.WAKE_SHORT(20), .WAKE_LONG(100), .STEP_UNIT(10)) i_fdxp_read (.pclk,
      .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .disk_in, .transfer_end_signal, .dma_acknowledge_n, .seek_done, .seek_fail,
      .dma_request, .byte_irq, .seek_start, .seek_cyl, .step_tick(), .osc_enable,
      .polling_enable, .precomp_active(), .awake(), .head_loaded());
   fdxp_dma_model i_fdxp_dma_model (.pclk, .presetn, .dma_request, .lag, .tc_at,
      .dma_acknowledge_n, .transfer_end_signal, .taken);
   always #25 pclk = ~pclk;
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic cmd(logic [7:0] b[9]);
      foreach (b[i]) apb(1'b1, ADDR_CMD, 32'(b[i]));
   endtask
   task automatic pio_read(logic [7:0] sec, int n);
      int k;
      cmd('{8'h40, 8'h0, 8'h0, 8'h0, sec, 8'h0, sec, 8'h0, 8'(n)});
      for (int i = 0; i < n; i++) begin
         while (byte_irq !== 1'b1) @(posedge pclk);
         apb(1'b0, ADDR_DATA, 32'h0);
         check("pio_byte", 32'(rd[7:0]), 32'(8'h80 | 8'(i)));
      end
      k = 0;
      repeat (4000) begin
         @(posedge pclk);
         if (byte_irq === 1'b1) k++;
      end
      check("pio_extra", 32'(k), 32'h0);
   endtask
   // Spinning track: ID byte, then data bytes with top bit set
   always begin
      for (int s = 1; s <= 4; s++)
         for (int i = -1; i < seclen; i++) begin
            repeat (15) @(posedge pclk);
            disk_in <= '{1'b1, 1'b0, 1'b1, i < 0 ? 8'(s) : 8'h80 | 8'(i)};
            @(posedge pclk);
            disk_in.valid <= 1'b0;
            disk_in.data <= ~disk_in.data;
         end
   end
   always @(posedge pclk) begin
      seek_done <= seek_start & !fail_seek;
      seek_fail <= seek_start & fail_seek;
      if (seek_start === 1'b1) check("seek_cyl", 32'(seek_cyl), 32'(want_cyl));
   end
   initial begin
      repeat (90000) @(posedge pclk);
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_CFG, 32'h0);
      check("cfg_reset", rd, 32'h0);
      check("osc_reset", 32'(osc_enable), 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped_err", 32'(err), 32'h1);
      for (int t = 0; t < 2; t++)
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, ADDR_RATE, 32'({t[1:0], c[1:0]}));
            apb(1'b0, ADDR_RATE, 32'h0);
            check("rate_read", 32'(rd[1:0]), (t == 1 && c == 2) ? 32'h3 : 32'(c));
         end
      apb(1'b1, ADDR_PERP, 32'h94);
      apb(1'b1, ADDR_PERP, 32'h28);
      apb(1'b0, ADDR_PERP, 32'h0);
      check("perp_flags", 32'(rd[5:2]), 32'h5);
      apb(1'b1, ADDR_CFG, 32'h434);
      @(posedge pclk);
      check("osc_off", 32'(osc_enable), 32'h0);
      check("poll_off", 32'(polling_enable), 32'h0);
      apb(1'b0, ADDR_DIR, 32'h0);
      check("dir_masked", 32'(rd[6:5]), 32'h0);
      apb(1'b1, ADDR_CFG, 32'h2005_0204);
      apb(1'b1, ADDR_RATE, 32'h80);
      apb(1'b0, ADDR_CFG, 32'h0);
      check("cfg_unlocked", rd & 32'hFF0F_0200, 32'h0);
      apb(1'b0, ADDR_DIR, 32'h0);
      check("dir_on", 32'(rd[6:5]), 32'h2);
      apb(1'b1, ADDR_CFG, 32'h2005_0201);
      apb(1'b1, ADDR_RATE, 32'h80);
      apb(1'b0, ADDR_CFG, 32'h0);
      check("cfg_locked", rd, 32'h2005_0201);
      // DMA read of two 256 byte sectors, cut short by terminal count
      apb(1'b1, ADDR_CFG, 32'h100);
      base = taken;
      tc_at <= taken + 16'h12C;
      want_cyl = 8'h05;
      cmd('{8'h40, 8'h0, 8'h05, 8'h0, 8'h01, 8'h01, 8'h02, 8'h0, 8'hFF});
      for (int k = 0; k < 30000 && taken - base < 16'h12C; k++) @(posedge pclk);
      repeat (5000) @(posedge pclk);
      check("dma_count", 32'(taken - base), 32'h12C);
      apb(1'b0, ADDR_RESULT, 32'h0);
      check("dma_status", 32'(rd[7:6]), 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status", 32'(rd[2:0]), 32'h7);
      tc_at <= 16'h0;
      fail_seek = 1'b1;
      want_cyl = 8'h09;
      cmd('{8'h40, 8'h0, 8'h09, 8'h0, 8'h01, 8'h01, 8'h01, 8'h0, 8'hFF});
      repeat (200) @(posedge pclk);
      apb(1'b0, ADDR_RESULT, 32'h0);
      check("seek_fail", 32'(rd[15:0]), 32'({8'h09, ERR_SEEK}));
      fail_seek = 1'b0;
      // Programmed io, short sectors, no result phase between commands
      seclen = 128;
      apb(1'b1, ADDR_CFG, 32'h1800);
      pio_read(8'h02, 5);
      pio_read(8'h03, 3);
      stop_test();
   end
endmodule
`default_nettype wire
